// *** verilog/ofe_ctrl_regs.sv ***
// Control register group of the optical front end: pin function, address
// key, software reset, operating mode and readback/FIFO policy.
// Assumes a serial bus engine that presents decoded word accesses,
// synchronous to clk_i, and pin levels already synchronised.
`timescale 1ns/10ps
`include "ofe_cfg.svh"
module ofe_ctrl_regs (
  input wire logic clk_i,
  input wire logic srst_i,
  // Decoded register access
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_wack_o,
  // Pin levels
  input wire logic general_pin_zero_i,
  input wire logic general_pin_one_i,
  // Events from the timing core
  input wire logic legacy_int_i,
  input wire logic int_i,
  input wire logic first_slot_start_i,
  input wire logic last_slot_end_i,
  input wire logic pulse_a_i,
  input wire logic pulse_b_i,
  input wire logic data_cycle_a_i,
  input wire logic data_cycle_b_i,
  input wire logic sample_i,
  input wire logic osc32k_i,
  // Configuration toward the device
  output logic general_pin_zero_o,
  output logic [4:0] pin_one_function_select_o,
  output logic [6:0] target_addr_o,
  output logic [1:0] op_mode_o,
  output logic extended_readback_format_o,
  output logic fifo_overrun_policy_o,
  output logic [11:0] slot_fifo_cfg_o,
  output logic soft_reset_o
);
  localparam ofe_pkg::ofe_regs_t RST_VAL = '{
    tgt: `OFE_TGT_RST,
    sel0: `OFE_SEL_RST,
    sel1: `OFE_SEL_RST,
    key: `OFE_KEY_RST,
    software_reset_bit: 1'b0,
    mode: `OFE_MODE_STBY,
    rdout: `OFE_RDOUT_RST,
    rdata: '0,
    rvalid: 1'b0,
    wack: 1'b0,
    sreset: 1'b0
  };

  ofe_pkg::ofe_regs_t q, d;
  ofe_ctl_if ctl ();
  logic [15:0] rd_word;
  logic wr_tgt, wr_rst, wr_mode, wr_rdout;

  // ==========================================================
  // Helpers
  assign ctl.pin_sel = q.sel0;
  assign ctl.clr = q.software_reset_bit;
  assign ctl.key = q.key;
  assign ctl.pin0_lvl = general_pin_zero_i;
  assign ctl.pin1_lvl = general_pin_one_i;

  ofe_addr_guard u_guard (
    .ctl(ctl.guard)
  );

  ofe_pin_mux u_pin (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ctl(ctl.mux),
    .legacy_int_i(legacy_int_i),
    .int_i(int_i),
    .first_slot_start_i(first_slot_start_i),
    .last_slot_end_i(last_slot_end_i),
    .pulse_a_i(pulse_a_i),
    .pulse_b_i(pulse_b_i),
    .data_cycle_a_i(data_cycle_a_i),
    .data_cycle_b_i(data_cycle_b_i),
    .sample_i(sample_i),
    .osc32k_i(osc32k_i)
  );

  // ==========================================================
  // Write decode
  always_comb begin
    wr_tgt = reg_wr_i && reg_addr_i == `OFE_ADDR_TGT;
    wr_rst = reg_wr_i && reg_addr_i == `OFE_ADDR_RST;
    wr_mode = reg_wr_i && reg_addr_i == `OFE_ADDR_MODE;
    wr_rdout = reg_wr_i && reg_addr_i == `OFE_ADDR_RDOUT;
  end

  // ==========================================================
  // Read mux; unmapped and write-only bits read zero
  always_comb begin
    rd_word = '0;
    case (reg_addr_i)
      `OFE_ADDR_TGT: begin
        rd_word[`OFE_TGT_F] = q.tgt;
      end
      `OFE_ADDR_PINCFG: begin
        rd_word[`OFE_SEL0_F] = q.sel0;
        rd_word[`OFE_SEL1_F] = q.sel1;
      end
      `OFE_ADDR_KEY: begin
        rd_word = q.key;
      end
      `OFE_ADDR_RST: begin
        rd_word[`OFE_RST_BIT] = q.software_reset_bit;
      end
      `OFE_ADDR_MODE: begin
        rd_word[`OFE_MODE_F] = q.mode;
      end
      `OFE_ADDR_RDOUT: begin
        rd_word[`OFE_RDOUT_F] = q.rdout;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.wack = 1'b0;
    d.rvalid = 1'b0;
    d.sreset = 1'b0;
    if (q.software_reset_bit) begin
      // Pending reset: restore every field, bit falls by itself
      d = RST_VAL;
      d.sreset = 1'b1;
    end else begin
      if (reg_wr_i) begin
        // Every write is acknowledged, a reset write included
        d.wack = 1'b1;
        case (reg_addr_i)
          `OFE_ADDR_TGT: begin
            // Upper byte must carry the key byte as well
            if (ctl.permit &&
                reg_wdata_i[`OFE_TGT_KEY_F] == `OFE_TGT_KEY) begin
              d.tgt = reg_wdata_i[`OFE_TGT_F];
            end
          end
          `OFE_ADDR_PINCFG: begin
            d.sel0 = reg_wdata_i[`OFE_SEL0_F];
            d.sel1 = reg_wdata_i[`OFE_SEL1_F];
          end
          `OFE_ADDR_KEY: begin
            d.key = reg_wdata_i;
          end
          `OFE_ADDR_RST: begin
            d.software_reset_bit = reg_wdata_i[`OFE_RST_BIT];
          end
          `OFE_ADDR_MODE: begin
            d.mode = reg_wdata_i[`OFE_MODE_F];
          end
          `OFE_ADDR_RDOUT: begin
            d.rdout = reg_wdata_i[`OFE_RDOUT_F];
          end
          default: begin
            d.wack = 1'b1;
          end
        endcase
      end
      if (reg_rd_i) begin
        d.rvalid = 1'b1;
        d.rdata = rd_word;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign reg_rdata_o = q.rdata;
  assign reg_rvalid_o = q.rvalid;
  assign reg_wack_o = q.wack;
  assign general_pin_zero_o = ctl.pin_out;
  assign pin_one_function_select_o = q.sel1;
  assign target_addr_o = q.tgt;
  assign op_mode_o = q.mode;
  assign extended_readback_format_o = q.rdout[`OFE_FMT_BIT];
  assign fifo_overrun_policy_o = q.rdout[`OFE_OVRN_BIT];
  assign slot_fifo_cfg_o = q.rdout[`OFE_SLOTCFG_F];
  assign soft_reset_o = q.sreset;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_reset_cmd;
    wr_rst && reg_wdata_i[`OFE_RST_BIT] && !q.software_reset_bit;
  endsequence

  sequence s_ack_then_standby;
    reg_wack_o && q.software_reset_bit
      ##1 soft_reset_o && op_mode_o == `OFE_MODE_STBY
        && target_addr_o == `OFE_TGT_RST && !q.software_reset_bit;
  endsequence

  a_reset_ack_standby: assert property (
    s_reset_cmd |=> s_ack_then_standby)
    else $error("reset write not acked then restored to standby");

  a_reset_bit_clears: assert property (
    q.software_reset_bit |=> !q.software_reset_bit ##1 !soft_reset_o)
    else $error("software reset bit did not clear itself");

  a_mode_write: assert property (
    wr_mode && !q.software_reset_bit
      |=> op_mode_o == $past(reg_wdata_i[`OFE_MODE_F]))
    else $error("operating mode not taken from write");

  a_tgt_locked: assert property (
    wr_tgt && !ctl.permit && !q.software_reset_bit
      |=> $stable(target_addr_o))
    else $error("target address changed without permission");

  a_tgt_always: assert property (
    wr_tgt && q.key == `OFE_KEY_ALWAYS && !q.software_reset_bit
      && reg_wdata_i[`OFE_TGT_KEY_F] == `OFE_TGT_KEY
      |=> target_addr_o == $past(reg_wdata_i[`OFE_TGT_F]))
    else $error("always key did not allow address change");

  a_key_pin_cond: assert property (
    (q.key == `OFE_KEY_PIN0 && !general_pin_zero_i)
      || (q.key == `OFE_KEY_PIN1 && !general_pin_one_i)
      || (q.key == `OFE_KEY_BOTH && !(general_pin_zero_i && general_pin_one_i))
      |-> !ctl.permit)
    else $error("pin-gated key permitted with pin low");

  a_format_bits: assert property (
    wr_rdout && !q.software_reset_bit
      |=> extended_readback_format_o == $past(reg_wdata_i[`OFE_FMT_BIT])
        && fifo_overrun_policy_o == $past(reg_wdata_i[`OFE_OVRN_BIT]))
    else $error("readback or overrun bit not taken from write");

  a_read_answer: assert property (
    reg_rd_i && !q.software_reset_bit && reg_addr_i == `OFE_ADDR_MODE
      |=> reg_rvalid_o && reg_rdata_o[`OFE_MODE_F] == $past(q.mode))
    else $error("mode readback wrong or late");

  // Pending reset swallows the access, so the host sees no answer
  a_busy_drop: assert property (
    q.software_reset_bit && (reg_wr_i || reg_rd_i)
      |=> !reg_wack_o && !reg_rvalid_o)
    else $error("access answered while reset pending");

  a_write_acked: assert property (
    reg_wr_i && !q.software_reset_bit |=> reg_wack_o)
    else $error("write not acknowledged");

  a_tgt_key_byte: assert property (
    wr_tgt && reg_wdata_i[`OFE_TGT_KEY_F] != `OFE_TGT_KEY && !q.software_reset_bit
      |=> $stable(target_addr_o))
    else $error("target address changed without key byte");

  a_tgt_pin_gated: assert property (
    wr_tgt && ctl.permit && q.key != `OFE_KEY_ALWAYS && !q.software_reset_bit
      && reg_wdata_i[`OFE_TGT_KEY_F] == `OFE_TGT_KEY
      |=> target_addr_o == $past(reg_wdata_i[`OFE_TGT_F]))
    else $error("pin-gated key did not allow address change");

  a_srst_defaults: assert property (
    $past(srst_i)
      |-> op_mode_o == `OFE_MODE_STBY && target_addr_o == `OFE_TGT_RST
        && q.rdout == `OFE_RDOUT_RST && !reg_wack_o && !reg_rvalid_o
        && !general_pin_zero_o && !soft_reset_o)
    else $error("state after bus reset differs from defaults");

  a_reset_restores: assert property (
    q.software_reset_bit
      |=> q.rdout == `OFE_RDOUT_RST && q.sel0 == `OFE_SEL_RST && q.sel1 == `OFE_SEL_RST
        && q.key == `OFE_KEY_RST && !general_pin_zero_o)
    else $error("software reset left a field off its default");

  a_rdata_holds: assert property (
    !reg_rd_i && !q.software_reset_bit |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  a_sel_write: assert property (
    reg_wr_i && reg_addr_i == `OFE_ADDR_PINCFG && !q.software_reset_bit
      |=> ctl.pin_sel == $past(reg_wdata_i[`OFE_SEL0_F])
        && pin_one_function_select_o == $past(reg_wdata_i[`OFE_SEL1_F]))
    else $error("pin select fields not taken from write");

  // ==========================================================
  // Pin zero, seen from the top; the mux output lags one cycle
  a_pin_legacy: assert property (
    ctl.pin_sel == `OFE_SEL_LEGACY && !ctl.clr
      |=> general_pin_zero_o == $past(legacy_int_i))
    else $error("pin zero does not follow legacy interrupt");

  a_pin_int: assert property (
    ctl.pin_sel == `OFE_SEL_INT && !ctl.clr
      |=> general_pin_zero_o == $past(int_i))
    else $error("pin zero does not follow interrupt");

  a_pin_pulse_both: assert property (
    ctl.pin_sel == `OFE_SEL_PAB && !ctl.clr
      |=> general_pin_zero_o == $past(pulse_a_i | pulse_b_i))
    else $error("pin zero does not show both pulse trains");

  a_pin_data_any: assert property (
    ctl.pin_sel == `OFE_SEL_DANY && !ctl.clr
      |=> general_pin_zero_o == $past(data_cycle_a_i | data_cycle_b_i))
    else $error("pin zero does not show any data cycle");

  a_pin_osc: assert property (
    ctl.pin_sel == `OFE_SEL_OSC && !ctl.clr
      |=> general_pin_zero_o == $past(osc32k_i))
    else $error("pin zero does not follow slow oscillator");

  a_window_close: assert property (
    ctl.pin_sel == `OFE_SEL_WIN && last_slot_end_i && !first_slot_start_i
      && !ctl.clr
      |=> !general_pin_zero_o)
    else $error("window pin did not fall at last slot end");
endmodule

// *** inc/ofe_cfg.svh ***
// Address map, field slices, codes and reset values of the control group.
// Included by the design files; holds definitions only.
`ifndef OFE_CFG_SVH
`define OFE_CFG_SVH

// Register word addresses
`define OFE_ADDR_TGT 8'h09
`define OFE_ADDR_PINCFG 8'h0b
`define OFE_ADDR_KEY 8'h0d
`define OFE_ADDR_RST 8'h0f
`define OFE_ADDR_MODE 8'h10
`define OFE_ADDR_RDOUT 8'h11

// Field slices
`define OFE_TGT_F 7:1
`define OFE_TGT_KEY_F 15:8
`define OFE_SEL0_F 4:0
`define OFE_SEL1_F 12:8
`define OFE_RST_BIT 0
`define OFE_MODE_F 1:0
`define OFE_RDOUT_F 13:0
`define OFE_FMT_BIT 13
`define OFE_OVRN_BIT 12
`define OFE_SLOTCFG_F 11:0

// Reset values and operating mode codes
`define OFE_TGT_RST 7'h64
`define OFE_SEL_RST 5'h00
`define OFE_KEY_RST 16'h0000
`define OFE_MODE_STBY 2'h0
`define OFE_MODE_PROG 2'h1
`define OFE_MODE_NORM 2'h2
`define OFE_RDOUT_RST 14'h1000

// Address-change keys
`define OFE_TGT_KEY 8'had
`define OFE_KEY_ALWAYS 16'h04ad
`define OFE_KEY_PIN0 16'h44ad
`define OFE_KEY_PIN1 16'h84ad
`define OFE_KEY_BOTH 16'hc4ad

// Pin zero function codes
`define OFE_SEL_LEGACY 5'h00
`define OFE_SEL_INT 5'h01
`define OFE_SEL_WIN 5'h02
`define OFE_SEL_PA 5'h05
`define OFE_SEL_PB 5'h06
`define OFE_SEL_PAB 5'h07
`define OFE_SEL_DA 5'h0c
`define OFE_SEL_DB 5'h0d
`define OFE_SEL_DANY 5'h0e
`define OFE_SEL_TOG 5'h0f
`define OFE_SEL_LOW 5'h10
`define OFE_SEL_HIGH 5'h11
`define OFE_SEL_OSC 5'h13

`endif

// *** inc/ofe_pkg.sv ***
// Types shared by the control register group.
// Widths follow the address map in ofe_cfg.svh.
package ofe_pkg;

  typedef struct packed {
    logic [6:0] tgt;
    logic [4:0] sel0;
    logic [4:0] sel1;
    logic [15:0] key;
    logic software_reset_bit;
    logic [1:0] mode;
    logic [13:0] rdout;
    logic [15:0] rdata;
    logic rvalid;
    logic wack;
    logic sreset;
  } ofe_regs_t;

  typedef struct packed {
    logic win;
    logic tog;
    logic out;
  } ofe_pin_t;

endpackage

// *** inc/ofe_ctl_if.sv ***
// Carrier between the register group and its pin and key helpers.
// One clock domain; all members are plain levels.
`timescale 1ns/10ps
interface ofe_ctl_if;
  logic [4:0] pin_sel;
  logic clr;
  logic pin_out;
  logic [15:0] key;
  logic pin0_lvl;
  logic pin1_lvl;
  logic permit;

  modport regs (output pin_sel, output clr, output key, output pin0_lvl,
    output pin1_lvl, input pin_out, input permit);
  modport mux (input pin_sel, input clr, output pin_out);
  modport guard (input key, input pin0_lvl, input pin1_lvl, output permit);
endinterface

// *** verilog/ofe_addr_guard.sv ***
// Decides whether the target address may change now.
// Assumes pin levels synchronous to the register clock.
`timescale 1ns/10ps
`include "ofe_cfg.svh"
module ofe_addr_guard (
  ofe_ctl_if.guard ctl
);
  // ==========================================================
  // Key decode
  always_comb begin
    case (ctl.key)
      `OFE_KEY_ALWAYS: ctl.permit = 1'b1;
      `OFE_KEY_PIN0: ctl.permit = ctl.pin0_lvl;
      `OFE_KEY_PIN1: ctl.permit = ctl.pin1_lvl;
      `OFE_KEY_BOTH: ctl.permit = ctl.pin0_lvl & ctl.pin1_lvl;
      default: ctl.permit = 1'b0;
    endcase
  end
endmodule

// *** verilog/ofe_pin_mux.sv ***
// Alternate function multiplexer of general pin zero.
// Event inputs come from the timing core, synchronous to clk_i.
`timescale 1ns/10ps
`include "ofe_cfg.svh"
module ofe_pin_mux (
  input wire logic clk_i,
  input wire logic srst_i,
  ofe_ctl_if.mux ctl,
  input wire logic legacy_int_i,
  input wire logic int_i,
  input wire logic first_slot_start_i,
  input wire logic last_slot_end_i,
  input wire logic pulse_a_i,
  input wire logic pulse_b_i,
  input wire logic data_cycle_a_i,
  input wire logic data_cycle_b_i,
  input wire logic sample_i,
  input wire logic osc32k_i
);
  ofe_pkg::ofe_pin_t q, d;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    if (first_slot_start_i) begin
      d.win = 1'b1;
    end else if (last_slot_end_i) begin
      d.win = 1'b0;
    end
    if (sample_i) begin
      d.tog = ~q.tog;
    end
    case (ctl.pin_sel)
      `OFE_SEL_LEGACY: d.out = legacy_int_i;
      `OFE_SEL_INT: d.out = int_i;
      `OFE_SEL_WIN: d.out = d.win;
      `OFE_SEL_PA: d.out = pulse_a_i;
      `OFE_SEL_PB: d.out = pulse_b_i;
      `OFE_SEL_PAB: d.out = pulse_a_i | pulse_b_i;
      `OFE_SEL_DA: d.out = data_cycle_a_i;
      `OFE_SEL_DB: d.out = data_cycle_b_i;
      `OFE_SEL_DANY: d.out = data_cycle_a_i | data_cycle_b_i;
      `OFE_SEL_TOG: d.out = d.tog;
      `OFE_SEL_LOW: d.out = 1'b0;
      `OFE_SEL_HIGH: d.out = 1'b1;
      `OFE_SEL_OSC: d.out = osc32k_i;
      // Unsupported codes park the pin low
      default: d.out = 1'b0;
    endcase
    if (ctl.clr) begin
      d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ctl.pin_out = q.out;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_pin_const_low: assert property (
    ctl.pin_sel == `OFE_SEL_LOW && !ctl.clr |=> !ctl.pin_out)
    else $error("pin not low under constant-low code");
  a_pin_const_high: assert property (
    ctl.pin_sel == `OFE_SEL_HIGH && !ctl.clr |=> ctl.pin_out)
    else $error("pin not high under constant-high code");
  a_window_open: assert property (
    ctl.pin_sel == `OFE_SEL_WIN && first_slot_start_i && !ctl.clr
      |=> ctl.pin_out)
    else $error("window pin did not rise at first slot start");
  a_toggle_flip: assert property (
    (ctl.pin_sel == `OFE_SEL_TOG && !ctl.clr)
      ##1 (ctl.pin_sel == `OFE_SEL_TOG && sample_i && !ctl.clr)
      |=> ctl.pin_out != $past(ctl.pin_out))
    else $error("toggle pin did not flip on sample");
endmodule

// *** verif/ofe_host.sv ***
// Host model driving the decoded register access port of the group.
// Assumes the answer is present by the falling edge after the taking edge.
`timescale 1ns/10ps
module ofe_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  input wire logic wack_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 16'h0000;
  end

  // ==========================================================
  // Word accesses
  // Strobe held across one rising edge; released data is inverted
  // so a stale bus value can never pass for a fresh one.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic ack);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
    addr_o = ~a;
    ack = wack_i;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
    ok = rvalid_i;
  endtask
endmodule

// *** verif/optical_afe_control_registers_test.sv ***
// Self-checking bench of the control register group.
// Assumes the host model above as sole bus master; events driven here.
`timescale 1ns/10ps
`include "ofe_cfg.svh"
module optical_afe_control_registers_test;
  logic clk_i, srst_i, wr, rd, rvalid, wack, pin0, pin1, pin_o, sres, fmt, ovrn;
  logic ack, ok, w, t;
  logic [7:0] addr, up;
  logic [15:0] wdata, rdata, d, k, v;
  logic [11:0] slotcfg;
  logic [9:0] ev, e;
  logic [6:0] tgt, a, tm;
  logic [4:0] sel1;
  logic [1:0] mode;
  int errors, compares;
  // Only listed codes are ever programmed
  logic [4:0] codes [13] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0c,
    5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h13};
  logic [15:0] keys [6] = '{16'h0000, 16'h04ad, 16'h44ad, 16'h84ad, 16'hc4ad, 16'h14ad};

  ofe_ctrl_regs u_ofe_ctrl_regs (
    .clk_i(clk_i), .srst_i(srst_i),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_wack_o(wack),
    .general_pin_zero_i(pin0), .general_pin_one_i(pin1),
    .legacy_int_i(ev[0]), .int_i(ev[1]), .first_slot_start_i(ev[2]),
    .last_slot_end_i(ev[3]), .pulse_a_i(ev[4]), .pulse_b_i(ev[5]),
    .data_cycle_a_i(ev[6]), .data_cycle_b_i(ev[7]), .sample_i(ev[8]),
    .osc32k_i(ev[9]), .general_pin_zero_o(pin_o),
    .pin_one_function_select_o(sel1), .target_addr_o(tgt), .op_mode_o(mode),
    .extended_readback_format_o(fmt), .fifo_overrun_policy_o(ovrn),
    .slot_fifo_cfg_o(slotcfg), .soft_reset_o(sres)
  );

  ofe_host u_ofe_host (
    .clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .wack_i(wack),
    .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata)
  );

  // ==========================================================
  // Checking and closing
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wrc(input logic [7:0] ad, input logic [15:0] val);
    u_ofe_host.wr(ad, val, ack);
    check("wack", ack, 1'b1);
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [15:0] exp);
    u_ofe_host.rd(ad, d, ok);
    check("rvalid", ok, 1'b1);
    check("rdata", d, exp);
  endtask

  task automatic soft_reset();
    wrc(`OFE_ADDR_RST, 16'h0001);
    @(negedge clk_i);
    check("soft_reset", sres, 1'b1);
  endtask

  // ==========================================================
  // Expectations
  function automatic logic permit(input logic [15:0] kv, input logic p0, input logic p1);
    case (kv)
      16'h04ad: permit = 1'b1;
      16'h44ad: permit = p0;
      16'h84ad: permit = p1;
      16'hc4ad: permit = p0 & p1;
      default: permit = 1'b0;
    endcase
  endfunction

  // Window and toggle are the already-updated states
  function automatic logic pin_exp(input logic [4:0] s, input logic [9:0] x, input logic wn,
    input logic tg);
    case (s)
      5'h00: pin_exp = x[0];
      5'h01: pin_exp = x[1];
      5'h02: pin_exp = wn;
      5'h05: pin_exp = x[4];
      5'h06: pin_exp = x[5];
      5'h07: pin_exp = x[4] | x[5];
      5'h0c: pin_exp = x[6];
      5'h0d: pin_exp = x[7];
      5'h0e: pin_exp = x[6] | x[7];
      5'h0f: pin_exp = tg;
      5'h11: pin_exp = 1'b1;
      5'h13: pin_exp = x[9];
      default: pin_exp = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Clock, watchdog, sequence
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // All waits are fixed; this only catches a stuck simulation
  initial begin
    #2000000;
    errors++;
    conclude();
  end

  initial begin
    srst_i = 1'b1;
    ev = 10'h000;
    pin0 = 1'b0;
    pin1 = 1'b0;
    errors = 0;
    compares = 0;
    void'($urandom(32'hac9c9952));
    repeat (10) @(negedge clk_i);
    srst_i = 1'b0;
    check("tgt", tgt, 7'h64);
    check("mode", mode, 2'h0);
    check("ovrn", ovrn, 1'b1);
    check("fmt", fmt, 1'b0);
    rdc(`OFE_ADDR_TGT, 16'h00c8);
    rdc(`OFE_ADDR_KEY, 16'h0000);
    rdc(`OFE_ADDR_RST, 16'h0000);
    rdc(`OFE_ADDR_MODE, 16'h0000);
    rdc(`OFE_ADDR_RDOUT, 16'h1000);
    rdc(8'h3f, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wrc(`OFE_ADDR_MODE, 16'(m));
      check("op_mode", mode, 16'(m));
      rdc(`OFE_ADDR_MODE, 16'(m));
    end
    for (int i = 0; i < 4; i++) begin
      v = (i < 2) ? {16{i[0]}} : 16'($urandom);
      wrc(`OFE_ADDR_RDOUT, v);
      check("fmt", fmt, v[13]);
      check("ovrn", ovrn, v[12]);
      check("slot_cfg", slotcfg, v[11:0]);
      rdc(`OFE_ADDR_RDOUT, v & 16'h3fff);
    end
    soft_reset();
    check("op_mode", mode, 2'h0);
    rdc(`OFE_ADDR_RDOUT, 16'h1000);
    rdc(`OFE_ADDR_RST, 16'h0000);
    tm = 7'h64;
    for (int i = 0; i < 24; i++) begin
      k = keys[i % 6];
      pin0 = 1'((i / 6) & 1);
      pin1 = 1'((i / 6) >> 1);
      up = (i < 18) ? 8'had : 8'h5a;
      a = 7'($urandom);
      wrc(`OFE_ADDR_KEY, k);
      rdc(`OFE_ADDR_KEY, k);
      wrc(`OFE_ADDR_TGT, {up, a, 1'b0});
      if (permit(k, pin0, pin1) && up == 8'had) begin
        tm = a;
      end
      check("target", tgt, tm);
      rdc(`OFE_ADDR_TGT, {8'h00, tm, 1'b0});
    end
    for (int c = 0; c < 13; c++) begin
      soft_reset();
      wrc(`OFE_ADDR_PINCFG, {3'h0, codes[12 - c], 3'h0, codes[c]});
      check("pin1_sel", sel1, codes[12 - c]);
      w = 1'b0;
      t = 1'b0;
      for (int n = 0; n < 40; n++) begin
        e = 10'($urandom);
        ev = e;
        @(negedge clk_i);
        t = t ^ e[8];
        w = e[2] ? 1'b1 : (e[3] ? 1'b0 : w);
        check("pin0", pin_o, pin_exp(codes[c], e, w, t));
      end
      ev = 10'h000;
    end
    conclude();
  end
endmodule
